/* File: bcsf_top.sv */
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// - Fault flag bit 7 sets on retry flag or enabled, soft-started, power not good.
// - Fault flag stays set until cleared; never follows condition back down.
// - Retry flag bit 6 latches on overcurrent end-of-count while power not good.
// - After retry latches, the retry-enable bit selects restart or shutdown response.
// - Negative current limit flag bit 5 latches when its comparator trips.
// - Zero-crossing flag bit 4 sets on detector trip while detector enabled.
// - Reserved bit 3 reads zero; software keeps it zero.
// - Bit 2 reads live soft-start-done, only while channel enabled.
// - Bit 1 reads the live power-good comparator.
// - Flag bits reset to zero; status read clears them, fault bit 7 only once retry bit 6 is clear; low bits read-only.
// - Bit 0 reads live channel-enabled status.
module bcsf_top
    import bcsf_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata_q,
    input wire bcsf_analog_s ana,
    output logic irq,
    output logic retry_restart,
    output logic retry_shutdown
);
    logic [7:0] mask_q;
    logic retry_en_q;
    logic status_rd;
    logic [3:0] flags_q;
    logic [3:0] flag_set;
    logic [7:0] status_val;
    bcsf_resp_e resp_q;
    bcsf_resp_e resp_d;

    bcsf_regs u_regs (
        .clk(clk),
        .srst(srst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata_q(),
        .mask_q(mask_q),
        .retry_en_q(retry_en_q)
    );

    // ==========================================================
    // Flag set conditions
    assign status_rd = rd && (addr == BCSF_STATUS_OFS);
    // Retry flag feeds fault in the same cycle it sets
    assign flag_set[2] = ana.oc_eoc && !ana.pgood;
    assign flag_set[3] = flag_set[2] || flags_q[2]
        || (ana.enabled && ana.ss_done && !ana.pgood);
    assign flag_set[1] = ana.neg_lim;
    assign flag_set[0] = ana.zc_trip && ana.zc_enable;

    // Sticky flags, set beats clear
    for (genvar i = 0; i < 4; i++) begin : g_flag
        bcsf_flag u_flag (
            .clk(clk),
            .srst(srst),
            .set(flag_set[i]),
            .clr(status_rd),
            .flag_q(flags_q[i])
        );
    end

    // ==========================================================
    // Read view
    always_comb begin
        status_val = BCSF_STATUS_RST;
        status_val[BCSF_FAULT_BIT] = flags_q[3];
        status_val[BCSF_RETRY_BIT] = flags_q[2];
        status_val[BCSF_NEGLIM_BIT] = flags_q[1];
        status_val[BCSF_ZCROSS_BIT] = flags_q[0];
        status_val[BCSF_RSVD_BIT] = 1'b0;
        status_val[BCSF_SSDONE_BIT] = ana.enabled && ana.ss_done;
        status_val[BCSF_PGOOD_BIT] = ana.pgood;
        status_val[BCSF_ENABLED_BIT] = ana.enabled;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                BCSF_STATUS_OFS: rdata_q <= status_val;
                BCSF_MASK_OFS: rdata_q <= mask_q;
                BCSF_CTRL_OFS: rdata_q <= {7'h00, retry_en_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign irq = |({flags_q, 4'h0} & mask_q);

    // ==========================================================
    // Response to a latched retry; held until the flag is read away
    always_comb begin
        resp_d = resp_q;
        if (!flags_q[2]) begin
            resp_d = BCSF_RUN;
        end else if (resp_q == BCSF_RUN) begin
            resp_d = retry_en_q ? BCSF_RETRY : BCSF_SHUTDOWN;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            resp_q <= BCSF_RUN;
        end else begin
            resp_q <= resp_d;
        end
    end

    assign retry_restart = (resp_q == BCSF_RETRY);
    assign retry_shutdown = (resp_q == BCSF_SHUTDOWN);

    // ==========================================================
    // Checks
    fault_on_retry_a: assert property (@(posedge clk) disable iff (srst)
        flag_set[2] |=> flags_q[3] && flags_q[2])
        else $error("fault not set with retry");
    fault_sticky_a: assert property (@(posedge clk) disable iff (srst)
        flags_q[3] && !status_rd |=> flags_q[3])
        else $error("fault dropped without read");
    retry_latch_a: assert property (@(posedge clk) disable iff (srst)
        ana.oc_eoc && !ana.pgood |=> flags_q[2])
        else $error("retry flag not latched");
    resp_choice_a: assert property (@(posedge clk) disable iff (srst)
        flags_q[2] && resp_q == BCSF_RUN && !retry_en_q |=> retry_shutdown)
        else $error("wrong retry response");
    neglim_latch_a: assert property (@(posedge clk) disable iff (srst)
        ana.neg_lim |=> flags_q[1])
        else $error("negative limit flag missed");
    zcross_gate_a: assert property (@(posedge clk) disable iff (srst)
        !flags_q[0] && !(ana.zc_trip && ana.zc_enable) |=> !flags_q[0])
        else $error("zero cross flag set unduly");
    rsvd_zero_a: assert property (@(posedge clk) disable iff (srst)
        $past(rd) |-> !rdata_q[BCSF_RSVD_BIT])
        else $error("reserved bit nonzero");
    live_bits_a: assert property (@(posedge clk) disable iff (srst)
        rd && addr == BCSF_STATUS_OFS |=> rdata_q[2:0]
            == {$past(ana.enabled && ana.ss_done), $past(ana.pgood), $past(ana.enabled)})
        else $error("live status wrong");
    read_clear_a: assert property (@(posedge clk) disable iff (srst)
        status_rd && !ana.neg_lim |=> !flags_q[1])
        else $error("read did not clear");
    set_wins_a: assert property (@(posedge clk) disable iff (srst)
        status_rd && ana.neg_lim |=> flags_q[1])
        else $error("event lost on read");
    fault_live_a: assert property (@(posedge clk) disable iff (srst)
        ana.enabled && ana.ss_done && !ana.pgood |=> flags_q[3])
        else $error("fault not set on lost power good");
    zcross_set_a: assert property (@(posedge clk) disable iff (srst)
        ana.zc_trip && ana.zc_enable |=> flags_q[0])
        else $error("zero cross flag missed");
    resp_restart_a: assert property (@(posedge clk) disable iff (srst)
        flags_q[2] && resp_q == BCSF_RUN && retry_en_q |=> retry_restart)
        else $error("restart response missing");
    resp_hold_a: assert property (@(posedge clk) disable iff (srst)
        flags_q[2] && resp_q != BCSF_RUN |=> resp_q == $past(resp_q))
        else $error("response changed while retry held");
    rdata_idle_a: assert property (@(posedge clk) disable iff (srst)
        !rd |=> rdata_q == 8'h00)
        else $error("read data not zero outside read");
    unmapped_read_a: assert property (@(posedge clk) disable iff (srst)
        rd && addr > BCSF_CTRL_OFS |=> rdata_q == 8'h00)
        else $error("unmapped read not zero");
endmodule

/* File: bcsf_pkg.sv */
package bcsf_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] BCSF_STATUS_OFS = 8'h00;
    localparam logic [7:0] BCSF_MASK_OFS = 8'h01;
    localparam logic [7:0] BCSF_CTRL_OFS = 8'h02;
    localparam logic [7:0] BCSF_STATUS_RST = 8'h00;
    localparam logic [7:0] BCSF_MASK_RST = 8'h00;

    // ==========================================================
    // Status bit positions
    localparam int BCSF_FAULT_BIT = 7;
    localparam int BCSF_RETRY_BIT = 6;
    localparam int BCSF_NEGLIM_BIT = 5;
    localparam int BCSF_ZCROSS_BIT = 4;
    localparam int BCSF_RSVD_BIT = 3;
    localparam int BCSF_SSDONE_BIT = 2;
    localparam int BCSF_PGOOD_BIT = 1;
    localparam int BCSF_ENABLED_BIT = 0;
    localparam logic [7:0] BCSF_FLAG_MASK = 8'hF0;
    localparam int BCSF_RETRY_EN_BIT = 0;

    // ==========================================================
    // Response chosen after an overcurrent retry latches
    typedef enum logic [1:0] {
        BCSF_RUN = 2'b00,
        BCSF_RETRY = 2'b01,
        BCSF_SHUTDOWN = 2'b10
    } bcsf_resp_e;

    typedef struct packed {
        logic enabled;
        logic ss_done;
        logic pgood;
        logic oc_eoc;
        logic neg_lim;
        logic zc_trip;
        logic zc_enable;
    } bcsf_analog_s;

endpackage

/* File: bcsf_flag.sv */
`timescale 1ns/1ns
module bcsf_flag (
    input wire logic clk,
    input wire logic srst,
    input wire logic set,
    input wire logic clr,
    output logic flag_q
);
    // Set wins over a clearing read so no event is lost
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end
endmodule

/* File: bcsf_regs.sv */
`timescale 1ns/1ns
module bcsf_regs
    import bcsf_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata_q,
    output logic [7:0] mask_q,
    output logic retry_en_q
);
    // ==========================================================
    // Writable mask and control registers
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_q <= BCSF_MASK_RST;
        end else if (wr && addr == BCSF_MASK_OFS) begin
            mask_q <= wdata & BCSF_FLAG_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            retry_en_q <= 1'b0;
        end else if (wr && addr == BCSF_CTRL_OFS) begin
            retry_en_q <= wdata[BCSF_RETRY_EN_BIT];
        end
    end

    assign rdata_q = 8'h00;
endmodule

/* File: bcsf_tb.sv */
`timescale 1ns/1ns
module tb;
    import bcsf_pkg::*;
    logic clk = 0;
    logic srst = 1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 0;
    logic rd = 0;
    logic rd_seen = 0;
    logic [7:0] rdata_q;
    bcsf_analog_s ana = '0;
    logic irq, retry_restart, retry_shutdown;
    logic [15:0] notes[$];
    logic [15:0] nt;
    logic c_prev, c_now;
    logic [2:0] lv;
    int num_errors = 0;
    int total_checks = 0;
    int seed = 35;

    always #20 clk = ~clk;

    bcsf_top DUT (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q), .ana(ana), .irq(irq), .retry_restart(retry_restart),
        .retry_shutdown(retry_shutdown));

    // ==========================================================
    // Bus and compare helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask

    task automatic idle;
        cyc(0, 0, 8'h00, 8'h00);
    endtask

    // Mask keeps bits whose value the check cannot predict out of the compare
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
        notes.push_back({exp, msk});
        cyc(0, 1, a, 8'h00);
        idle();
    endtask

    task automatic ev(input logic [6:0] v);
        ana <= v;
        idle();
        ana <= 7'h70;
        idle();
    endtask

    always @(posedge clk) begin
        if (rd_seen) begin
            nt = notes.pop_front();
            chk(rdata_q & nt[7:0], nt[15:8]);
        end
        rd_seen <= rd;
    end

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        repeat (16) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        rdc(BCSF_STATUS_OFS, 8'h00, 8'hFF);
        ana <= 7'h30;
        idle();
        rdc(BCSF_STATUS_OFS, 8'h02, 8'hFF);
        ev(7'h74);
        rdc(BCSF_STATUS_OFS, 8'h27, 8'hFF);
        rdc(BCSF_STATUS_OFS, 8'h07, 8'hFF);
        ev(7'h72);
        rdc(BCSF_STATUS_OFS, 8'h07, 8'hFF);
        ev(7'h73);
        rdc(BCSF_STATUS_OFS, 8'h17, 8'hFF);
        ana <= 7'h74;
        notes.push_back({8'h07, 8'hFF});
        cyc(0, 1, BCSF_STATUS_OFS, 8'h00);
        ana <= 7'h70;
        idle();
        rdc(BCSF_STATUS_OFS, 8'h27, 8'hFF);
        cyc(1, 0, BCSF_STATUS_OFS, 8'hFF);
        cyc(1, 0, BCSF_MASK_OFS, 8'hF0);
        idle();
        rdc(BCSF_STATUS_OFS, 8'h07, 8'hFF);
        rdc(8'h7F, 8'h00, 8'hFF);
        ev(7'h74);
        chk({7'h00, irq}, 8'h01);
        rdc(BCSF_STATUS_OFS, 8'h27, 8'hFF);
        chk({7'h00, irq}, 8'h00);
        cyc(1, 0, BCSF_MASK_OFS, 8'h00);
        ev(7'h74);
        chk({7'h00, irq}, 8'h00);
        srst <= 1;
        idle();
        srst <= 0;
        idle();
        rdc(BCSF_STATUS_OFS, 8'h07, 8'hFF);
        ana <= 7'h08;
        idle();
        ana <= 7'h00;
        idle();
        // Response register follows the flag by one edge
        idle();
        chk({6'h00, retry_restart, retry_shutdown}, 8'h01);
        rdc(BCSF_STATUS_OFS, 8'hC0, 8'hFF);
        rdc(BCSF_STATUS_OFS, 8'h00, 8'h7F);
        rdc(BCSF_STATUS_OFS, 8'h00, 8'hFF);
        cyc(1, 0, BCSF_CTRL_OFS, 8'h01);
        ana <= 7'h08;
        idle();
        ana <= 7'h00;
        idle();
        idle();
        chk({6'h00, retry_restart, retry_shutdown}, 8'h02);
        rdc(BCSF_STATUS_OFS, 8'h40, 8'h7F);
        rdc(BCSF_STATUS_OFS, 8'h00, 8'h7F);
        rdc(BCSF_STATUS_OFS, 8'h00, 8'hFF);
        ev(7'h60);
        rdc(BCSF_STATUS_OFS, 8'h87, 8'hFF);
        rdc(BCSF_STATUS_OFS, 8'h07, 8'hFF);
        c_prev = 0;
        repeat (24) begin
            lv = 3'($random(seed));
            c_now = lv[2] & lv[1] & ~lv[0];
            ana <= {lv, 4'h0};
            idle();
            rdc(BCSF_STATUS_OFS, {c_prev | c_now, 4'h0, lv[2] & lv[1], lv[0], lv[2]}, 8'hFF);
            c_prev = c_now;
        end
        ana <= 7'h00;
        idle();
        rdc(BCSF_STATUS_OFS, {c_prev, 7'h00}, 8'hFF);
        wrap_up();
    end

    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
endmodule
